// File: motion_fifo_status_regs_defines.svh
// offsets, field positions, reset values and sizes of the motion/queue regs
`ifndef MOTION_FIFO_STATUS_REGS_DEFINES_SVH
`define MOTION_FIFO_STATUS_REGS_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define MOVEMENT_CTRL_ADDR    8'h09
`define QUEUE_STATUS_ADDR     8'h0a
`define QUEUE_READ_INDEX_ADDR 8'h0b
`define SAMPLE_FIRST_ADDR     8'h0d
`define SAMPLE_LAST_ADDR      8'h12

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MOVEMENT_CTRL_RESET   8'h00
`define QUEUE_STATUS_RESET    8'h01
`define QUEUE_INDEX_RESET     6'h00

// ----------------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------------
`define QUEUE_EMPTY_BIT       0
`define QUEUE_FULL_BIT        1
`define QUEUE_LEVEL_BIT       2

// ----------------------------------------------------------------------
// queue sizing
// ----------------------------------------------------------------------
`define QUEUE_DEPTH           32
`define QUEUE_INDEX_W         6
`define QUEUE_LEVEL_DEFAULT   6'h10
`define QUEUE_FULL_COUNT      6'h20

`endif

// File: motion_fifo_status_pkg.sv
// types shared by the motion control and queue status register block
package motion_fifo_status_pkg;

    // ------------------------------------------------------------------
    // register access request from the parallel register port host
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic       write;
        logic       read;
        logic [7:0] wdata;
    } reg_req_t;

    // ------------------------------------------------------------------
    // movement control byte, bit 7 down to bit 0
    // ------------------------------------------------------------------
    typedef struct packed {
        logic engine_reset;
        logic unfiltered_flag_select;
        logic z_polarity_select;
        logic steep_tilt_detect_on;
        logic shake_detect_on;
        logic any_movement_detect_on;
        logic latch_outputs;
        logic tilt_flip_detect_on;
    } motion_ctrl_t;

    // ------------------------------------------------------------------
    // one acquired sample, x low bytes first in the address map
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] z;
        logic [15:0] y;
        logic [15:0] x;
    } sample_t;

endpackage

// File: motion_fifo_status_regs.sv
// movement control, queue status and queue read index registers
// Summary of operation
// - write-only movement control byte at 0x09, resets to 0x00.
// - bit 0 turns tilt/flip detection on; off after reset.
// - bit 1 makes the motion engine latch its outputs.
// - bit 2 turns any-movement detection on; off after reset.
// - bit 5 picks z polarity; 0 means out of package top.
// - bit 6 picks raw flags; 0 means debounced flags.
// - bit 7 holds motion engine in reset until host rewrites it.
// - read-only queue status at 0x0A, resets to 0x01, live flags.
// - status flags ignore queue interrupt enables elsewhere.
// - status bit 0 shows queue empty, valid enabled or not.
// - status bit 1 shows queue full, valid enabled or not.
// - status bit 2 shows fill level at or above threshold.
// - threshold is 16 entries, half of 32.
// - status bits 7 to 3 read zero.
// - read-only 6-bit queue read index at 0x0B, resets to zero.
// - low five index bits address locations 0 to 31.
// - index bit 5 is a wrap flag for full/empty compare.
// - read index bits 7 and 6 read zero.
// - queue enable steers reads from 0x0D to queued samples.
// - write index advances on each valid sample while queue is enabled and not full.
`timescale 1ns/1ps
`default_nettype none
`include "motion_fifo_status_regs_defines.svh"

module motion_fifo_status_regs (
    input  wire logic                                mclk,
    input  wire logic                                arst_n,
    input  wire motion_fifo_status_pkg::reg_req_t    regReq,
    output logic [7:0]                               regRdata,
    input  wire logic                                queueEnable,
    input  wire logic                                sampleValid,
    input  wire motion_fifo_status_pkg::sample_t     sampleData,
    output motion_fifo_status_pkg::motion_ctrl_t     motionCtrl,
    output logic                                     motionEngineReset
);
    import motion_fifo_status_pkg::*;

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    motion_ctrl_t                 motionCtrl_reg;
    logic [`QUEUE_INDEX_W-1:0]    readIndex_reg;
    logic [`QUEUE_INDEX_W-1:0]    writeIndex_reg;
    logic [`QUEUE_INDEX_W-1:0]    readIndex_next;
    logic [`QUEUE_INDEX_W-1:0]    writeIndex_next;
    sample_t                      latest_reg;
    logic [7:0]                   rdata_reg;
    logic [7:0]                   rdata_next;
    sample_t                      queueMem [`QUEUE_DEPTH];

    logic                         queueEmpty;
    logic                         queueFull;
    logic                         queueLevelFlag;
    logic [`QUEUE_INDEX_W-1:0]    fillLevel;
    logic                         pushOk;
    logic                         popOk;
    logic [7:0]                   statusByte;
    logic [7:0]                   indexByte;
    logic [2:0]                   sampleIdx;
    logic [7:0]                   sampleOff;

    // ------------------------------------------------------------------
    // byte pick from a sample, shared by queue and latest paths
    // ------------------------------------------------------------------
    function automatic logic [7:0] sampleByte(input sample_t s,
                                              input logic [2:0] idx);
        logic [7:0] b;
        b = 8'h00;
        unique case (idx)
            3'h0: b = s.x[7:0];
            3'h1: b = s.x[15:8];
            3'h2: b = s.y[7:0];
            3'h3: b = s.y[15:8];
            3'h4: b = s.z[7:0];
            3'h5: b = s.z[15:8];
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    function automatic logic inSampleWindow(input logic [7:0] a);
        return (a >= `SAMPLE_FIRST_ADDR) && (a <= `SAMPLE_LAST_ADDR);
    endfunction

    // ------------------------------------------------------------------
    // movement control byte
    // ------------------------------------------------------------------
    // bits are stored as written; shake and steep-tilt depending on
    // any-movement is left to the host
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            motionCtrl_reg <= motion_ctrl_t'(`MOVEMENT_CTRL_RESET);
        end else if (regReq.write &&
                     regReq.addr == `MOVEMENT_CTRL_ADDR) begin
            motionCtrl_reg <= motion_ctrl_t'(regReq.wdata);
        end
    end

    // each field drives the motion engine directly
    // latch select and enables pass as stored
    // polarity and raw selects pass as stored
    assign motionCtrl = motionCtrl_reg;
    // no self-clear: engine stays in reset until rewritten
    assign motionEngineReset = motionCtrl_reg.engine_reset;

    // ------------------------------------------------------------------
    // queue pointers
    // ------------------------------------------------------------------
    // full and empty compare all six bits; wrap bit breaks the tie
    assign queueEmpty = (readIndex_reg == writeIndex_reg);
    assign queueFull  = (readIndex_reg[4:0] == writeIndex_reg[4:0]) &&
                        (readIndex_reg[5] != writeIndex_reg[5]);
    assign fillLevel  = writeIndex_reg - readIndex_reg;
    assign queueLevelFlag = (fillLevel >= `QUEUE_LEVEL_DEFAULT);

    // a sample arriving while full is dropped rather than overwriting
    assign pushOk = sampleValid && queueEnable && !queueFull;
    // pop only when the host finishes a burst at the last sample byte
    assign popOk  = regReq.read && regReq.addr == `SAMPLE_LAST_ADDR &&
                    queueEnable && !queueEmpty;

    assign writeIndex_next = writeIndex_reg + 6'h01;
    assign readIndex_next  = readIndex_reg + 6'h01;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            writeIndex_reg <= `QUEUE_INDEX_RESET;
        end else if (pushOk) begin
            writeIndex_reg <= writeIndex_next;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            readIndex_reg <= `QUEUE_INDEX_RESET;
        end else if (popOk) begin
            readIndex_reg <= readIndex_next;
        end
    end

    // memory has no reset; contents are meaningless until written
    always_ff @(posedge mclk) begin
        if (pushOk) begin
            queueMem[writeIndex_reg[4:0]] <= sampleData;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            latest_reg <= '0;
        end else if (sampleValid) begin
            latest_reg <= sampleData;
        end
    end

    // ------------------------------------------------------------------
    // read side
    // ------------------------------------------------------------------
    // flags are live pointer compares, no interrupt mask
    always_comb begin
        statusByte = 8'h00;
        statusByte[`QUEUE_EMPTY_BIT] = queueEmpty;
        statusByte[`QUEUE_FULL_BIT]  = queueFull;
        statusByte[`QUEUE_LEVEL_BIT] = queueLevelFlag;
    end

    assign indexByte = {2'b00, readIndex_reg};
    assign sampleOff = regReq.addr - `SAMPLE_FIRST_ADDR;
    assign sampleIdx = sampleOff[2:0];

    always_comb begin
        rdata_next = 8'h00;
        if (regReq.addr == `QUEUE_STATUS_ADDR) begin
            rdata_next = statusByte;
        end else if (regReq.addr == `QUEUE_READ_INDEX_ADDR) begin
            rdata_next = indexByte;
        end else if (inSampleWindow(regReq.addr)) begin
            if (queueEnable) begin
                rdata_next = sampleByte(queueMem[readIndex_reg[4:0]],
                                        sampleIdx);
            end else begin
                rdata_next = sampleByte(latest_reg, sampleIdx);
            end
        end
    end

    // control byte is write-only, so its address reads zero
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= 8'h00;
        end else if (regReq.read) begin
            rdata_reg <= rdata_next;
        end
    end

    assign regRdata = rdata_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    // independent occupancy count for the flag checks
    logic [`QUEUE_INDEX_W-1:0] chkCount;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            chkCount <= 6'h00;
        end else begin
            chkCount <= chkCount + {5'h00, pushOk} - {5'h00, popOk};
        end
    end

    sequence s_ctrl_write;
        regReq.write && regReq.addr == `MOVEMENT_CTRL_ADDR;
    endsequence

    sequence s_push_into_empty;
        queueEmpty && pushOk;
    endsequence

    sequence s_status_read;
        regReq.read && regReq.addr == `QUEUE_STATUS_ADDR;
    endsequence

    property p_ctrl_write;
        s_ctrl_write |=> motionCtrl == $past(regReq.wdata);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("control byte not loaded by write");

    property p_ctrl_hold;
        !(regReq.write && regReq.addr == `MOVEMENT_CTRL_ADDR)
            |=> $stable(motionEngineReset) && $stable(motionCtrl);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold)
        else $error("control byte changed without a write");

    property p_empty_clear;
        s_push_into_empty |=> !queueEmpty && chkCount == 6'h01;
    endproperty
    a_empty_clear: assert property (p_empty_clear)
        else $error("empty flag stayed set after a push");

    property p_full_count;
        queueFull == (chkCount == `QUEUE_FULL_COUNT);
    endproperty
    a_full_count: assert property (p_full_count)
        else $error("full flag disagrees with occupancy");

    property p_level_count;
        queueLevelFlag == (chkCount >= `QUEUE_LEVEL_DEFAULT);
    endproperty
    a_level_count: assert property (p_level_count)
        else $error("level flag disagrees with occupancy");

    property p_status_read;
        s_status_read |=> regRdata == $past(statusByte) &&
                          regRdata[7:3] == 5'h00;
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read returned wrong byte");

    property p_index_read;
        regReq.read && regReq.addr == `QUEUE_READ_INDEX_ADDR
            |=> regRdata == {2'b00, $past(readIndex_reg)};
    endproperty
    a_index_read: assert property (p_index_read)
        else $error("read index byte wrong");

    property p_pop_advance;
        popOk |=> readIndex_reg == $past(readIndex_reg) + 6'h01;
    endproperty
    a_pop_advance: assert property (p_pop_advance)
        else $error("read index did not advance on pop");

    property p_full_drop;
        sampleValid && queueFull |=> $stable(writeIndex_reg);
    endproperty
    a_full_drop: assert property (p_full_drop)
        else $error("write index moved while full");

    sequence s_pop_at_top;
        popOk && readIndex_reg[4:0] == 5'h1f;
    endsequence

    sequence s_push_to_level;
        pushOk && !popOk && chkCount == 6'h0f;
    endsequence

    property p_empty_count;
        queueEmpty == (chkCount == 6'h00);
    endproperty
    a_empty_count: assert property (p_empty_count)
        else $error("empty flag disagrees with occupancy");

    property p_push_advance;
        pushOk |=> writeIndex_reg == $past(writeIndex_reg) + 6'h01;
    endproperty
    a_push_advance: assert property (p_push_advance)
        else $error("write index did not advance on push");

    property p_disabled_drop;
        sampleValid && !queueEnable |=> $stable(writeIndex_reg);
    endproperty
    a_disabled_drop: assert property (p_disabled_drop)
        else $error("write index moved while queue disabled");

    property p_pop_only_at_end;
        !popOk |=> $stable(readIndex_reg);
    endproperty
    a_pop_only_at_end: assert property (p_pop_only_at_end)
        else $error("read index moved without a burst end");

    property p_read_wrap;
        s_pop_at_top |=> readIndex_reg[4:0] == 5'h00 &&
                         readIndex_reg[5] != $past(readIndex_reg[5]);
    endproperty
    a_read_wrap: assert property (p_read_wrap)
        else $error("read index wrap bit did not toggle");

    property p_level_rise;
        s_push_to_level |=> queueLevelFlag;
    endproperty
    a_level_rise: assert property (p_level_rise)
        else $error("level flag not set at threshold");

    property p_ctrl_readback;
        regReq.read && regReq.addr == `MOVEMENT_CTRL_ADDR
            |=> regRdata == 8'h00;
    endproperty
    a_ctrl_readback: assert property (p_ctrl_readback)
        else $error("write-only control byte read back nonzero");

    property p_rdata_hold;
        !regReq.read |=> $stable(regRdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without a read");

endmodule
`default_nettype wire

// File: host_register_master.sv
// host-side master for the parallel register port
`timescale 1ns/1ps
`default_nettype none
`include "motion_fifo_status_regs_defines.svh"

module host_register_master (
    input  wire logic                             mclk,
    output var  motion_fifo_status_pkg::reg_req_t regReq,
    input  wire logic [7:0]                       regRdata
);
    import motion_fifo_status_pkg::*;

    initial regReq = '0;

    // ------------------------------------------------------------------
    // one strobe per byte; released data shows inverse, not stale value
    // ------------------------------------------------------------------
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == `MOVEMENT_CTRL_ADDR && (d[3] || d[4])) begin
            v[2] = 1'b1;
        end
        @(posedge mclk);
        regReq <= '{addr: a, write: 1'b1, read: 1'b0, wdata: v};
        @(posedge mclk);
        regReq.write <= 1'b0;
        regReq.wdata <= ~v;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        regReq <= '{addr: a, write: 1'b0, read: 1'b1, wdata: 8'h00};
        @(posedge mclk);
        regReq.read <= 1'b0;
        #1 d = regRdata;
    endtask
endmodule
`default_nettype wire

// File: tb_motion_fifo_status_regs.sv
// self-checking bench for the movement control and queue status regs
`timescale 1ns/1ps
`default_nettype none
`include "motion_fifo_status_regs_defines.svh"

module tb_motion_fifo_status_regs;
    import motion_fifo_status_pkg::*;

    logic         mclk;
    logic         arst_n;
    logic         queueEnable;
    logic         sampleValid;
    logic         motionEngineReset;
    logic [7:0]   regRdata;
    reg_req_t     regReq;
    sample_t      sampleData;
    motion_ctrl_t motionCtrl;
    int           n_mismatch;
    int           cmp_count;

    motion_fifo_status_regs uut (
        .mclk(mclk), .arst_n(arst_n), .regReq(regReq),
        .regRdata(regRdata), .queueEnable(queueEnable),
        .sampleValid(sampleValid), .sampleData(sampleData),
        .motionCtrl(motionCtrl), .motionEngineReset(motionEngineReset));

    host_register_master host (
        .mclk(mclk), .regReq(regReq), .regRdata(regRdata));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host.read_reg(a, v);
        check(v, exp);
    endtask

    function automatic sample_t mk(input logic [7:0] k);
        return '{z: 16'h3000 + k, y: 16'h2000 + k, x: 16'h1000 + k};
    endfunction

    function automatic logic [7:0] stat(input int n);
        return {5'h00, n >= 16, n == `QUEUE_DEPTH, n == 0};
    endfunction

    // drops the valid data afterwards so a late capture sees garbage
    task automatic push(input logic [7:0] k);
        @(posedge mclk);
        sampleValid <= 1'b1;
        sampleData  <= mk(k);
        @(posedge mclk);
        sampleValid <= 1'b0;
        sampleData  <= ~mk(k);
    endtask

    task automatic rd_sample(input logic [7:0] k);
        sample_t s;
        s = mk(k);
        for (int i = 0; i < 6; i++) begin
            rd_check(`SAMPLE_FIRST_ADDR + 8'(i), s[8*i +: 8]);
        end
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic sc_reset();
        rd_check(`QUEUE_STATUS_ADDR, 8'h01);
        rd_check(`QUEUE_READ_INDEX_ADDR, 8'h00);
        check(motionCtrl, 8'h00);
        check({7'h00, motionEngineReset}, 8'h00);
        rd_check(`MOVEMENT_CTRL_ADDR, 8'h00);
    endtask

    task automatic sc_ctrl();
        logic [7:0] e;
        for (int i = 0; i < 8; i++) begin
            e = 8'h01 << i;
            if (i == 3 || i == 4) begin
                e[2] = 1'b1;
            end
            host.write_reg(`MOVEMENT_CTRL_ADDR, e);
            #1;
            check(motionCtrl, e);
            check({7'h00, motionEngineReset}, {7'h00, e[7]});
        end
        repeat (5) @(posedge mclk);
        #1;
        check({7'h00, motionEngineReset}, 8'h01);
        host.write_reg(`QUEUE_STATUS_ADDR, 8'hff);
        #1;
        check(motionCtrl, 8'h80);
        rd_check(`QUEUE_STATUS_ADDR, 8'h01);
        host.write_reg(`MOVEMENT_CTRL_ADDR, 8'h00);
        #1;
        check({7'h00, motionEngineReset}, 8'h00);
    endtask

    // disabled queue keeps empty but the latest sample still shows
    task automatic sc_latest();
        push(8'h55);
        rd_check(`QUEUE_STATUS_ADDR, 8'h01);
        rd_sample(8'h55);
        rd_check(`QUEUE_READ_INDEX_ADDR, 8'h00);
    endtask

    // 33rd push meets a full queue and must be dropped
    task automatic sc_fill();
        int n;
        for (int k = 1; k <= 33; k++) begin
            push(8'(k));
            n = k > 32 ? 32 : k;
            rd_check(`QUEUE_STATUS_ADDR, stat(n));
        end
    endtask

    task automatic sc_drain(input logic [5:0] base);
        logic [7:0] idx;
        for (int k = 1; k <= 32; k++) begin
            rd_sample(8'(k));
            idx = {2'b00, base + 6'(k)};
            rd_check(`QUEUE_READ_INDEX_ADDR, idx);
            rd_check(`QUEUE_STATUS_ADDR, stat(32 - k));
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // main sequence; second fill wraps the indexes through bit 5
    // ------------------------------------------------------------------
    initial begin
        n_mismatch = 0;
        cmp_count = 0;
        arst_n = 1'b0;
        queueEnable = 1'b0;
        sampleValid = 1'b0;
        sampleData = '0;
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        sc_reset();
        sc_ctrl();
        sc_latest();
        @(posedge mclk);
        queueEnable <= 1'b1;
        sc_fill();
        sc_drain(6'h00);
        sc_fill();
        sc_drain(6'h20);
        // leave state away from reset so the second reset proves itself
        host.write_reg(`MOVEMENT_CTRL_ADDR, 8'h85);
        push(8'h77);
        rd_check(`QUEUE_STATUS_ADDR, 8'h00);
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        sc_reset();
        give_verdict();
    end
endmodule
`default_nettype wire
